// ---- hw/writable_control_store_ops.sv ----
// Execution logic for the writable microcode store and its four instructions.
// What this block does
// - Fixed store below 800, writable store from 800 up to FFF.
// - Every store word is 32 bits, one microinstruction.
// - Opcode E80 copies memory into the store; base gr0, count gr1.
// - Each word lands at base plus count; count then drops by one.
// - Copies are interruptible; location counter stays unincremented to resume.
// - Opcode E82 copies the store into memory; base gr2, count gr3.
// - Count gr3 drops per word; copy ends when count passes below zero.
// - Reads of the fixed region give undefined data, here zero.
// - Branch jumps to low 12 bits of the operand address, unchecked.
// - Enter jumps to writable base plus the 4-bit first register field.
// - Both branches hand current and incremented location counter to microcode.
// - Branches leave condition code to microcode; copies keep it unchanged.
// - All four instructions run only in supervisor state.
`timescale 1ns/100ps
module writable_control_store_ops (
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    input  wire logic               issue_valid,
    output logic                    issue_ready,
    input  wire ustore_pkg::issue_t issue,
    input  wire logic               supervisor,
    input  wire logic               irq_pending,
    output ustore_pkg::done_t       done,
    output ustore_pkg::branch_t     branch,
    output logic                    gr_wr_en,
    input  wire logic               gr_wr_ready,
    output logic [3:0]              gr_wr_idx,
    output ustore_pkg::word_t       gr_wr_data,
    output logic                    mem_req_valid,
    input  wire logic               mem_req_ready,
    output ustore_pkg::mem_req_t    mem_req,
    input  wire logic               mem_rvalid,
    input  wire ustore_pkg::word_t  mem_rdata,
    input  wire logic [11:0]        useq_addr,
    output ustore_pkg::word_t       useq_data
);
    ustore_pkg::state_t  state_q;
    ustore_pkg::state_t  state_d;
    ustore_pkg::word_t   r2_q;
    ustore_pkg::word_t   base_q;
    ustore_pkg::word_t   iss_cnt_q;
    ustore_pkg::word_t   drn_cnt_q;
    logic                iss_fin_q;
    logic                drn_fin_q;
    logic                stop_q;
    logic                rd_out_q;
    ustore_pkg::word_t   store_q [ustore_pkg::WR_DEPTH];
    ustore_pkg::done_t   done_q;
    ustore_pkg::branch_t branch_q;
    ustore_pkg::word_t   useq_q;
    logic                f_in_valid;
    logic                f_in_ready;
    ustore_pkg::word_t   f_in_data;
    logic                f_out_valid;
    logic                f_out_ready;
    ustore_pkg::word_t   f_out_data;

    function automatic logic writable(input logic [11:0] a);
        return a >= ustore_pkg::WR_BASE;
    endfunction

    function automatic logic [10:0] store_idx(input logic [11:0] a);
        return a[10:0];
    endfunction

    // Instruction decode.
    wire is_to_us  = (issue.opcode == ustore_pkg::OP_COPY)
                  && (issue.first_register_field == ustore_pkg::SUB_TO_US);
    wire is_to_mem = (issue.opcode == ustore_pkg::OP_COPY)
                  && (issue.first_register_field == ustore_pkg::SUB_TO_MEM);
    wire is_branch = issue.opcode == ustore_pkg::OP_BRANCH;
    wire is_enter  = issue.opcode == ustore_pkg::OP_ENTER;
    wire is_jump   = is_branch || is_enter;
    wire is_ours   = is_to_us || is_to_mem || is_jump;
    wire take      = issue_valid && issue_ready;
    wire start_w   = take && is_to_us && supervisor;
    wire start_r   = take && is_to_mem && supervisor;
    wire jump_go   = take && is_jump && supervisor;

    wire [11:0] jump_target = is_enter
        ? ustore_pkg::WR_BASE + {8'h00, issue.first_register_field}
        : issue.operand_addr[11:0];

    // Copy data path.
    wire in_copy_w = state_q == ustore_pkg::ST_TO_US;
    wire in_copy_r = state_q == ustore_pkg::ST_TO_MEM;
    wire in_copy   = in_copy_w || in_copy_r;
    wire iss_ok    = !iss_fin_q && !stop_q;

    wire ustore_pkg::word_t iss_sum = base_q + iss_cnt_q;
    wire ustore_pkg::word_t drn_sum = base_q + drn_cnt_q;
    wire [11:0] rd_addr = iss_sum[11:0];
    wire [11:0] wr_addr = drn_sum[11:0];
    wire ustore_pkg::word_t rd_word = writable(rd_addr)
        ? store_q[store_idx(rd_addr)] : '0;

    wire mem_rd_go = in_copy_w && iss_ok && !rd_out_q && f_in_ready;
    wire pop       = f_out_valid && f_out_ready;
    wire iss_step  = in_copy_r ? (f_in_valid && f_in_ready)
                               : (mem_rd_go && mem_req_ready);
    wire ustore_we = pop && in_copy_w && writable(wr_addr);
    wire finish    = in_copy && !f_out_valid && !rd_out_q
                  && (drn_fin_q || stop_q);

    wire ustore_pkg::word_t mem_cnt = in_copy_r ? drn_cnt_q : iss_cnt_q;

    assign f_in_valid  = in_copy_r ? iss_ok : (rd_out_q && mem_rvalid);
    assign f_in_data   = in_copy_r ? rd_word : mem_rdata;
    assign f_out_ready = gr_wr_ready && (in_copy_w || (in_copy_r && mem_req_ready));

    assign mem_req_valid = mem_rd_go || (in_copy_r && f_out_valid && gr_wr_ready);
    assign mem_req.we    = in_copy_r;
    assign mem_req.addr  = r2_q + {mem_cnt[29:0], 2'b00};
    assign mem_req.wdata = f_out_data;

    assign gr_wr_en   = pop;
    assign gr_wr_idx  = in_copy_r ? ustore_pkg::GR_CNT_R : ustore_pkg::GR_CNT_W;
    assign gr_wr_data = drn_cnt_q - 32'h00000001;

    assign issue_ready = state_q == ustore_pkg::ST_IDLE;
    assign done        = done_q;
    assign branch      = branch_q;
    assign useq_data   = useq_q;

    ustore_fifo #(
        .WIDTH (ustore_pkg::WORD_W),
        .DEPTH (ustore_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ustore_pkg::ST_IDLE:
            begin
                if (start_w)
                begin
                    state_d = ustore_pkg::ST_TO_US;
                end
                else if (start_r)
                begin
                    state_d = ustore_pkg::ST_TO_MEM;
                end
            end
            ustore_pkg::ST_TO_US,
            ustore_pkg::ST_TO_MEM:
            begin
                if (finish)
                begin
                    state_d = ustore_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_d = ustore_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            state_q <= ustore_pkg::ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Word store of the writable region, 32 bits per microinstruction.
    always_ff @(posedge clk_sys)
    begin
        if (ustore_we)
        begin
            store_q[store_idx(wr_addr)] <= f_out_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            useq_q <= '0;
        end
        else
        begin
            useq_q <= writable(useq_addr) ? store_q[store_idx(useq_addr)] : '0;
        end
    end

    // Copy counters; a negative starting count copies nothing.
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            r2_q      <= '0;
            base_q    <= '0;
            iss_cnt_q <= '0;
            drn_cnt_q <= '0;
            iss_fin_q <= 1'b0;
            drn_fin_q <= 1'b0;
        end
        else if (start_w || start_r)
        begin
            r2_q      <= issue.second_register_value;
            base_q    <= start_w ? issue.gr0 : issue.gr2;
            iss_cnt_q <= start_w ? issue.gr1 : issue.gr3;
            drn_cnt_q <= start_w ? issue.gr1 : issue.gr3;
            iss_fin_q <= start_w ? issue.gr1[31] : issue.gr3[31];
            drn_fin_q <= start_w ? issue.gr1[31] : issue.gr3[31];
        end
        else
        begin
            if (iss_step)
            begin
                iss_cnt_q <= iss_cnt_q - 32'h00000001;
                iss_fin_q <= iss_cnt_q == '0;
            end
            if (pop)
            begin
                drn_cnt_q <= drn_cnt_q - 32'h00000001;
                drn_fin_q <= drn_cnt_q == '0;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            stop_q   <= 1'b0;
            rd_out_q <= 1'b0;
        end
        else
        begin
            if (start_w || start_r)
            begin
                stop_q <= 1'b0;
            end
            else if (in_copy && irq_pending)
            begin
                stop_q <= 1'b1;
            end
            if (mem_rd_go && mem_req_ready)
            begin
                rd_out_q <= 1'b1;
            end
            else if (mem_rvalid)
            begin
                rd_out_q <= 1'b0;
            end
        end
    end

    // Completion report and branch hand-off.
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            done_q   <= '0;
            branch_q <= '0;
        end
        else
        begin
            done_q   <= '0;
            branch_q <= '0;
            if (take && !is_ours)
            begin
                done_q.valid   <= 1'b1;
                done_q.illegal <= 1'b1;
            end
            else if (take && !supervisor)
            begin
                done_q.valid      <= 1'b1;
                done_q.priv_fault <= 1'b1;
            end
            else if (jump_go)
            begin
                done_q.valid     <= 1'b1;
                done_q.cc_keep   <= 1'b0;
                branch_q.valid   <= 1'b1;
                branch_q.target  <= jump_target;
                branch_q.lc_cur  <= issue.lc_cur;
                branch_q.lc_inc  <= issue.lc_inc;
            end
            else if (finish)
            begin
                done_q.valid      <= 1'b1;
                done_q.cc_keep    <= 1'b1;
                done_q.lc_advance <= drn_fin_q;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_jump;
        jump_go;
    endsequence

    sequence s_enter;
        jump_go && is_enter;
    endsequence

    sequence s_last_word;
        pop && (drn_cnt_q == '0);
    endsequence

    a_wr_region: assert property (ustore_we |=> $past(wr_addr[11])
        && store_q[$past(store_idx(wr_addr))] == $past(f_out_data))
        else $error("Store write missed or reached the fixed store.");
    a_ro_read_zero: assert property (
        in_copy_r && f_in_valid && !rd_addr[11] |-> f_in_data == '0)
        else $error("Fixed store read gave data.");
    a_count_step: assert property (gr_wr_en |=> drn_cnt_q == $past(gr_wr_data))
        else $error("Count did not follow the written value.");
    a_to_us_start: assert property (
        start_w |=> in_copy_w && base_q == $past(issue.gr0) && drn_cnt_q == $past(issue.gr1))
        else $error("Memory to store copy loaded wrongly.");
    a_to_mem_start: assert property (
        start_r |=> in_copy_r && base_q == $past(issue.gr2) && drn_cnt_q == $past(issue.gr3))
        else $error("Store to memory copy loaded wrongly.");
    a_copy_end: assert property (s_last_word |-> ##2 done_q.valid && done_q.lc_advance)
        else $error("Copy did not end after count zero.");
    a_resume_lc: assert property (
        finish && !drn_fin_q |=> done_q.valid && !done_q.lc_advance && issue_ready)
        else $error("Interrupted copy advanced the location counter.");
    a_branch_target: assert property (
        s_jump |=> branch_q.valid
            && ($past(is_enter) || branch_q.target == $past(issue.operand_addr[11:0])))
        else $error("Branch target wrong.");
    a_enter_target: assert property (
        s_enter |=> branch_q.target
            == ustore_pkg::WR_BASE + {8'h00, $past(issue.first_register_field)})
        else $error("Entry target wrong.");
    a_lc_pair: assert property (
        s_jump |=> branch_q.lc_cur == $past(issue.lc_cur)
            && branch_q.lc_inc == $past(issue.lc_inc))
        else $error("Location counter values not handed over.");
    a_cc_rules: assert property (
        done_q.valid && !done_q.priv_fault && !done_q.illegal |-> done_q.cc_keep != branch_q.valid)
        else $error("Condition code ownership wrong.");
    a_priv_block: assert property (
        take && is_ours && !supervisor |=> done_q.priv_fault && !branch_q.valid && issue_ready)
        else $error("Privileged instruction ran outside supervisor state.");
endmodule

// ---- include/ustore_pkg.sv ----
// Shared constants and carrier types for the writable microcode store block.
package ustore_pkg;
    localparam int unsigned WORD_W     = 32;
    localparam int unsigned WR_DEPTH   = 2048;
    localparam int unsigned FIFO_DEPTH = 32;
    localparam logic [11:0] WR_BASE    = 12'h800;
    localparam logic [11:0] USTORE_TOP = 12'hFFF;
    localparam logic [7:0]  OP_COPY    = 8'hE8;
    localparam logic [3:0]  SUB_TO_US  = 4'h0;
    localparam logic [3:0]  SUB_TO_MEM = 4'h2;
    localparam logic [7:0]  OP_BRANCH  = 8'hE5;
    localparam logic [7:0]  OP_ENTER   = 8'hE9;
    localparam logic [3:0]  GR_CNT_W   = 4'h1;
    localparam logic [3:0]  GR_CNT_R   = 4'h3;

    typedef logic [WORD_W-1:0] word_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_TO_US   = 2'b01,
        ST_TO_MEM  = 2'b10
    } state_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [3:0] first_register_field;
        word_t      second_register_value;
        word_t      operand_addr;
        word_t      lc_cur;
        word_t      lc_inc;
        word_t      gr0;
        word_t      gr1;
        word_t      gr2;
        word_t      gr3;
    } issue_t;

    typedef struct packed {
        logic valid;
        logic lc_advance;
        logic cc_keep;
        logic priv_fault;
        logic illegal;
    } done_t;

    typedef struct packed {
        logic        valid;
        logic [11:0] target;
        word_t       lc_cur;
        word_t       lc_inc;
    } branch_t;

    typedef struct packed {
        logic  we;
        word_t addr;
        word_t wdata;
    } mem_req_t;
endpackage

// ---- hw/ustore_fifo.sv ----
// Word FIFO that sits in the copy data path.
`timescale 1ns/100ps
module ustore_fifo #(
    parameter int unsigned WIDTH = ustore_pkg::WORD_W,
    parameter int unsigned DEPTH = ustore_pkg::FIFO_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;
    wire [AW-1:0] wr_nx = (wr_q == LAST) ? '0 : wr_q + 1'b1;
    wire [AW-1:0] rd_nx = (rd_q == LAST) ? '0 : rd_q + 1'b1;

    assign in_ready  = cnt_q != FULL;
    assign out_valid = cnt_q != '0;
    assign out_data  = mem_q[rd_q];

    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_nx;
            end
            if (pop)
            begin
                rd_q <= rd_nx;
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ---- sim/ustore_mem_model.sv ----
// Main memory model on the far side of the copy port.
`timescale 1ns/100ps
module ustore_mem_model (
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    input  wire logic                 slow,
    input  wire logic                 mem_req_valid,
    output logic                      mem_req_ready,
    input  wire ustore_pkg::mem_req_t mem_req,
    output logic                      mem_rvalid,
    output ustore_pkg::word_t         mem_rdata
);
    logic [31:0] wr_mem [logic [31:0]];
    logic        toggle_q;
    wire logic   take;
    wire logic   rd_take;

    assign take = mem_req_valid && mem_req_ready;
    assign rd_take = take && !mem_req.we;
    assign mem_req_ready = !slow || toggle_q;

    // Reads answer one cycle after acceptance; between answers the data lines keep changing.
    always @(posedge clk_sys)
    begin
        toggle_q <= reset_n && !toggle_q;
        mem_rvalid <= reset_n && rd_take;
        mem_rdata <= !reset_n ? 32'h0 : rd_take ? {16'hD000, mem_req.addr[15:0]} : ~mem_rdata;
        if (reset_n && take && mem_req.we)
        begin
            wr_mem[mem_req.addr] = mem_req.wdata;
        end
    end
endmodule

// ---- sim/tb_writable_control_store_ops.sv ----
// Self-checking bench for the writable microcode store instructions.
`timescale 1ns/100ps
module tb_writable_control_store_ops;
    logic                 clk_sys;
    logic                 reset_n;
    logic                 issue_valid;
    logic                 issue_ready;
    ustore_pkg::issue_t   issue;
    logic                 supervisor;
    logic                 irq_pending;
    ustore_pkg::done_t    done;
    ustore_pkg::branch_t  branch;
    logic                 gr_wr_en;
    logic                 gr_wr_ready;
    logic [3:0]           gr_wr_idx;
    ustore_pkg::word_t    gr_wr_data;
    logic                 mem_req_valid;
    logic                 mem_req_ready;
    ustore_pkg::mem_req_t mem_req;
    logic                 mem_rvalid;
    ustore_pkg::word_t    mem_rdata;
    logic [11:0]          useq_addr;
    ustore_pkg::word_t    useq_data;
    logic                 slow;
    logic [35:0]          wq[$];
    int                   num_errors;
    int                   checks_done;
    int                   cycles;

    writable_control_store_ops dut_u (.clk_sys, .reset_n, .issue_valid, .issue_ready, .issue,
        .supervisor, .irq_pending, .done, .branch, .gr_wr_en, .gr_wr_ready, .gr_wr_idx,
        .gr_wr_data, .mem_req_valid, .mem_req_ready, .mem_req, .mem_rvalid, .mem_rdata,
        .useq_addr, .useq_data);

    ustore_mem_model mem_u (.clk_sys, .reset_n, .slow, .mem_req_valid, .mem_req_ready,
        .mem_req, .mem_rvalid, .mem_rdata);

    always #25 clk_sys = ~clk_sys;

    // Records every accepted count-register write and cuts a hang short.
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (reset_n && gr_wr_en && gr_wr_ready)
            wq.push_back({gr_wr_idx, gr_wr_data});
        if (cycles == 20000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check_val(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic ustore_pkg::issue_t mk(input logic [7:0] op, input logic [3:0] r1,
        input logic [31:0] r2v, oa, g0, g1, g2, g3);
        mk = '{op, r1, r2v, oa, 32'h0000_1234, 32'h0000_1238, g0, g1, g2, g3};
    endfunction

    task automatic run_op(input ustore_pkg::issue_t i, input logic sup,
                          output ustore_pkg::done_t d, output ustore_pkg::branch_t b);
        b = '0;
        issue <= i;
        supervisor <= sup;
        issue_valid <= 1'b1;
        do
            @(negedge clk_sys);
        while (issue_ready !== 1'b1);
        @(posedge clk_sys);
        issue_valid <= 1'b0;
        do
        begin
            @(negedge clk_sys);
            if (branch.valid === 1'b1)
                b = branch;
        end
        while (done.valid !== 1'b1);
        d = done;
        @(posedge clk_sys);
    endtask

    task automatic read_store(input logic [11:0] a, input logic [31:0] exp, input string what);
        useq_addr <= a;
        @(posedge clk_sys);
        @(negedge clk_sys);
        check_val(useq_data, exp, what);
        @(posedge clk_sys);
    endtask

    task automatic t_jumps;
        logic [31:0] oa [4] = '{32'h0000_0000, 32'h1234_57FF, 32'hFFFF_F800, 32'h0000_0FFF};
        logic [3:0]  r1 [4] = '{4'h0, 4'h5, 4'hA, 4'hF};
        ustore_pkg::done_t   d;
        ustore_pkg::branch_t b;
        for (int i = 0; i < 8; i++)
        begin
            run_op(mk(i < 4 ? 8'hE5 : 8'hE9, r1[i % 4], 32'h0, oa[i % 4], 32'h0, 32'h0,
                      32'h0, 32'h0), 1'b1, d, b);
            check_val(b.valid, 1'b1, "branch taken");
            check_val(b.target, i < 4 ? oa[i % 4][11:0] : 12'h800 + r1[i % 4],
                      "branch target");
            check_val({b.lc_cur, b.lc_inc}, 64'h0000_1234_0000_1238, "location pair");
            check_val({d.cc_keep, d.priv_fault, d.illegal}, 3'b000, "jump status");
        end
    endtask

    task automatic t_refuse;
        logic [11:0] ops [6] = '{12'hE80, 12'hE82, 12'hE50, 12'hE93, 12'hE81, 12'h120};
        ustore_pkg::done_t   d;
        ustore_pkg::branch_t b;
        for (int i = 0; i < 6; i++)
        begin
            wq.delete();
            run_op(mk(ops[i][11:4], ops[i][3:0], 32'h0000_3000, 32'h0000_0800, 32'h0000_0800,
                      32'h0, 32'h0000_0800, 32'h0), i > 3, d, b);
            check_val({b.valid, d.priv_fault, d.illegal}, i > 3 ? 3'b001 : 3'b010,
                      "refused status");
            check_val(wq.size(), 0, "no register write");
        end
    endtask

    task automatic t_copy_in;
        ustore_pkg::done_t   d;
        ustore_pkg::branch_t b;
        int                  n;
        wq.delete();
        slow <= 1'b1;
        fork
            run_op(mk(8'hE8, 4'h0, 32'h0000_1000, 32'h0, 32'h0000_0800, 32'd19, 32'h0,
                      32'h0), 1'b1, d, b);
            begin
                while (wq.size() < 5)
                    @(posedge clk_sys);
                irq_pending <= 1'b1;
            end
        join
        irq_pending <= 1'b0;
        n = wq.size();
        check_val(d.lc_advance, n == 20, "advance only when complete");
        check_val(d.cc_keep, 1'b1, "copy keeps condition code");
        run_op(mk(8'hE8, 4'h0, 32'h0000_1000, 32'h0, 32'h0000_0800, 32'(19 - n), 32'h0,
                  32'h0), 1'b1, d, b);
        check_val(d.lc_advance, 1'b1, "resumed copy complete");
        check_val(wq.size(), 20, "word total");
        for (int k = 0; k < 20; k++)
        begin
            check_val(wq[k], {4'h1, 32'(18 - k)}, "count register write");
            read_store(12'(12'h800 + k), {16'hD000, 16'h1000 + 16'(4 * k)},
                       "store word");
        end
    endtask

    task automatic t_copy_out;
        ustore_pkg::done_t   d;
        ustore_pkg::branch_t b;
        wq.delete();
        gr_wr_ready <= 1'b0;
        fork
            run_op(mk(8'hE8, 4'h2, 32'h0000_2000, 32'h0, 32'h0, 32'h0, 32'h0000_07F0,
                      32'd47), 1'b1, d, b);
            begin
                repeat (60) @(negedge clk_sys);
                check_val({issue_ready, mem_req_valid, gr_wr_en}, 3'b000,
                          "held by register file");
                @(posedge clk_sys);
                gr_wr_ready <= 1'b1;
            end
        join
        check_val({d.lc_advance, d.cc_keep}, 2'b11, "copy out complete");
        check_val(wq.size(), 48, "word total");
        for (int k = 0; k < 48; k++)
        begin
            check_val(wq[k], {4'h3, 32'(46 - k)}, "count register write");
            check_val(mem_u.wr_mem.exists(32'h2000 + 4 * (47 - k)), 1'b1, "memory write");
        end
        for (int c = 0; c < 36; c++)
            check_val(mem_u.wr_mem[32'h2000 + 4 * c],
                      c < 16 ? 32'h0 : {16'hD000, 16'h1000 + 16'(4 * (c - 16))},
                      "copied word");
        slow <= 1'b0;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        reset_n = 1'b0;
        issue_valid = 1'b0;
        issue = '0;
        supervisor = 1'b0;
        irq_pending = 1'b0;
        gr_wr_ready = 1'b1;
        useq_addr = 12'h000;
        slow = 1'b0;
        num_errors = 0;
        checks_done = 0;
        cycles = 0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_jumps();
        t_refuse();
        t_copy_in();
        t_copy_out();
        read_store(12'h000, 32'h0, "fixed region read");
        read_store(12'h7FF, 32'h0, "fixed region top");
        tally_and_finish();
    end
endmodule
